//--- rtl/cmpc_defines.svh
// offsets, field positions, reset values and timing counts of the comparator
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH

`define CMPC_ADDR_W 8
`define CMPC_DATA_W 8

`define CMPC_OFF_DIG_IN_DIS 8'h01
`define CMPC_OFF_CONV_CTL_B 8'h03
`define CMPC_OFF_CMP_CTL 8'h08

`define CMPC_RST_DIG_IN_DIS 8'h00
`define CMPC_RST_CONV_CTL_B 8'h00
`define CMPC_RST_CMP_CTL 8'h00

`define CMPC_CTL_POWER_OFF 7
`define CMPC_CTL_BANDGAP 6
`define CMPC_CTL_RESULT 5
`define CMPC_CTL_FLAG 4
`define CMPC_CTL_IRQ_EN 3
`define CMPC_CTL_ROUTE 2
`define CMPC_CTL_MODE_HI 1
`define CMPC_CTL_MODE_LO 0

`define CMPC_CB_BIPOLAR 7
`define CMPC_CB_BORROW 6
`define CMPC_CB_LEFT_ADJ 4
`define CMPC_CB_TRIG_HI 2
`define CMPC_CB_TRIG_LO 0
`define CMPC_CB_WR_MASK 8'hD7

`define CMPC_CHAN_HI_ZERO 2'h0
`define CMPC_SYNC_STAGES 2
`define CMPC_PIN_COUNT 8

`endif

//--- rtl/cmpc_pkg.sv
// types shared by the comparator control files
package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_MODE_TOGGLE = 2'h0,
    CMPC_MODE_RESERVED = 2'h1,
    CMPC_MODE_FALL = 2'h2,
    CMPC_MODE_RISE = 2'h3
  } cmpc_mode_t;

endpackage

//--- rtl/cmpc_sync.sv
// two-flop synchroniser for the raw comparator level
`timescale 1ns/100ps
`default_nettype none

module cmpc_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous-released reset, low active
  input wire logic en_i, // clock enable
  input wire logic d_i, // asynchronous level
  output logic q_o // synchronised level
);

  logic [STAGES-1:0] chain_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_q <= '0;
    end else if (en_i) begin
      chain_q <= {chain_q[STAGES-2:0], d_i};
    end
  end

  assign q_o = chain_q[STAGES-1];

endmodule // cmpc_sync
`default_nettype wire

//--- rtl/cmpc_edge.sv
// edge detector and sticky interrupt flag of the comparator
`timescale 1ns/100ps
`default_nettype none

module cmpc_edge (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // reset, low active
  input wire logic en_i, // clock enable
  input wire logic level_i, // synchronised result
  input wire cmpc_pkg::cmpc_mode_t mode_i, // event selection
  input wire logic clear_i, // write-one-to-clear pulse
  input wire logic ack_i, // vector taken pulse
  output logic flag_o // sticky flag
);

  logic prev_q;
  logic event_d;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else if (en_i) begin
      prev_q <= level_i;
    end
  end

  always_comb begin
    case (mode_i)
      cmpc_pkg::CMPC_MODE_TOGGLE: event_d = level_i ^ prev_q;
      cmpc_pkg::CMPC_MODE_FALL: event_d = prev_q & ~level_i;
      cmpc_pkg::CMPC_MODE_RISE: event_d = level_i & ~prev_q;
      default: event_d = 1'b0;
    endcase
  end

  // set wins over either clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (en_i) begin
      if (event_d) begin
        flag_o <= 1'b1;
      end else if (clear_i || ack_i) begin
        flag_o <= 1'b0;
      end
    end
  end

endmodule // cmpc_edge
`default_nettype wire

//--- rtl/cmpc_top.sv
// comparator control: registers, input selection, result, interrupt
`timescale 1ns/100ps
`default_nettype none
`include "cmpc_defines.svh"

module cmpc_top #(
  parameter int SYNC_STAGES = `CMPC_SYNC_STAGES,
  parameter int PIN_COUNT = `CMPC_PIN_COUNT
) (
  input wire logic CLOCK_I, // system clock, 10 MHz
  input wire logic ARST_N_I, // asynchronous reset, low active
  input wire logic CLK_EN_I, // freezes all state except the reset synchroniser when low
  input wire logic [`CMPC_ADDR_W-1:0] ADDR_I, // register address
  input wire logic [`CMPC_DATA_W-1:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [`CMPC_DATA_W-1:0] RDATA_O, // read data, cycle after read
  input wire logic CMP_RAW_I, // raw analog comparator output
  input wire logic CONVERTER_ENABLE_I, // converter enable bit
  input wire logic [4:0] CHANNEL_SELECT_I, // converter mux select bits
  input wire logic GLOBAL_IRQ_EN_I, // global interrupt enable
  input wire logic IRQ_ACK_I, // interrupt vector taken pulse
  input wire logic [PIN_COUNT-1:0] PIN_RAW_I, // digital pin levels
  output logic [PIN_COUNT-1:0] PIN_READ_O, // pin-read values
  output logic [PIN_COUNT-1:0] PIN_BUF_OFF_O, // input buffer disables
  output logic CMP_POWER_OFF_O, // comparator power switched off
  output logic BANDGAP_SELECT_O, // positive input from bandgap
  output logic NEG_USE_PIN_O, // negative input from dedicated pin
  output logic [2:0] NEG_CHANNEL_O, // channel pin for negative input
  output logic CAPTURE_O, // result towards timer capture front end
  output logic IRQ_O // comparator interrupt request
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic en;

  logic [`CMPC_DATA_W-1:0] dig_in_dis_q;
  logic bipolar_q;
  logic mux_borrow_enable_q;
  logic left_adjust_q;
  logic [2:0] trigger_select_q;
  logic cmp_power_off_q;
  logic bandgap_select_q;
  logic cmp_irq_enable_q;
  logic capture_route_enable_q;
  cmpc_pkg::cmpc_mode_t irq_mode_q;

  logic cmp_result;
  logic cmp_irq_flag;
  logic raw_gated;
  logic flag_clear;
  logic [`CMPC_DATA_W-1:0] rdata_d;
  logic [`CMPC_DATA_W-1:0] conv_ctl_b;
  logic [`CMPC_DATA_W-1:0] cmp_ctl;
  logic borrow_active;

  function automatic logic hit(
    input logic [`CMPC_ADDR_W-1:0] addr,
    input logic [`CMPC_ADDR_W-1:0] offset
  );
    hit = (addr == offset);
  endfunction

  // reset release through two flops
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];
  assign en = CLK_EN_I;

  // digital input disable register
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      dig_in_dis_q <= `CMPC_RST_DIG_IN_DIS;
    end else if (en && WR_I && hit(ADDR_I, `CMPC_OFF_DIG_IN_DIS)) begin
      dig_in_dis_q <= WDATA_I;
    end
  end

  // converter control B, reserved bits not stored
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      bipolar_q <= 1'b0;
      mux_borrow_enable_q <= 1'b0;
      left_adjust_q <= 1'b0;
      trigger_select_q <= 3'h0;
    end else if (en && WR_I && hit(ADDR_I, `CMPC_OFF_CONV_CTL_B)) begin
      bipolar_q <= WDATA_I[`CMPC_CB_BIPOLAR];
      mux_borrow_enable_q <= WDATA_I[`CMPC_CB_BORROW];
      left_adjust_q <= WDATA_I[`CMPC_CB_LEFT_ADJ];
      trigger_select_q <= WDATA_I[`CMPC_CB_TRIG_HI:`CMPC_CB_TRIG_LO];
    end
  end

  // comparator control, result and flag bits are not plain storage
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      cmp_power_off_q <= 1'b0;
      bandgap_select_q <= 1'b0;
      cmp_irq_enable_q <= 1'b0;
      capture_route_enable_q <= 1'b0;
      irq_mode_q <= cmpc_pkg::CMPC_MODE_TOGGLE;
    end else if (en && WR_I && hit(ADDR_I, `CMPC_OFF_CMP_CTL)) begin
      cmp_power_off_q <= WDATA_I[`CMPC_CTL_POWER_OFF];
      bandgap_select_q <= WDATA_I[`CMPC_CTL_BANDGAP];
      cmp_irq_enable_q <= WDATA_I[`CMPC_CTL_IRQ_EN];
      capture_route_enable_q <= WDATA_I[`CMPC_CTL_ROUTE];
      irq_mode_q <= cmpc_pkg::cmpc_mode_t'(
        WDATA_I[`CMPC_CTL_MODE_HI:`CMPC_CTL_MODE_LO]);
    end
  end

  // unpowered comparator presents a low result
  assign raw_gated = CMP_RAW_I & ~cmp_power_off_q;

  cmpc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .en_i(en),
    .d_i(raw_gated),
    .q_o(cmp_result)
  );

  assign flag_clear = WR_I && hit(ADDR_I, `CMPC_OFF_CMP_CTL)
    && WDATA_I[`CMPC_CTL_FLAG];

  cmpc_edge u_edge (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .en_i(en),
    .level_i(cmp_result),
    .mode_i(irq_mode_q),
    .clear_i(flag_clear),
    .ack_i(IRQ_ACK_I),
    .flag_o(cmp_irq_flag)
  );

  // interrupt request, flag gated by enable and global enable
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_O <= 1'b0;
    end else if (en) begin
      IRQ_O <= cmp_irq_flag & cmp_irq_enable_q
        & GLOBAL_IRQ_EN_I & ~IRQ_ACK_I;
    end
  end

  // result towards timer capture
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      CAPTURE_O <= 1'b0;
    end else if (en) begin
      CAPTURE_O <= capture_route_enable_q & cmp_result;
    end
  end

  // converter enable blocks borrowing of its multiplexer
  assign borrow_active = mux_borrow_enable_q & ~CONVERTER_ENABLE_I
    & (CHANNEL_SELECT_I[4:3] == `CMPC_CHAN_HI_ZERO);

  // negative input selection
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      NEG_USE_PIN_O <= 1'b1;
      NEG_CHANNEL_O <= 3'h0;
    end else if (en) begin
      if (borrow_active) begin
        NEG_USE_PIN_O <= 1'b0;
        NEG_CHANNEL_O <= CHANNEL_SELECT_I[2:0];
      end else begin
        NEG_USE_PIN_O <= 1'b1;
        NEG_CHANNEL_O <= 3'h0;
      end
    end
  end

  // positive input and power controls
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      BANDGAP_SELECT_O <= 1'b0;
      CMP_POWER_OFF_O <= 1'b0;
    end else if (en) begin
      BANDGAP_SELECT_O <= bandgap_select_q;
      CMP_POWER_OFF_O <= cmp_power_off_q;
    end
  end

  // digital input buffers and pin reads
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      PIN_BUF_OFF_O <= '0;
      PIN_READ_O <= '0;
    end else if (en) begin
      PIN_BUF_OFF_O <= dig_in_dis_q[PIN_COUNT-1:0];
      PIN_READ_O <= PIN_RAW_I & ~dig_in_dis_q[PIN_COUNT-1:0];
    end
  end

  // read images
  always_comb begin
    conv_ctl_b = 8'h00;
    conv_ctl_b[`CMPC_CB_BIPOLAR] = bipolar_q;
    conv_ctl_b[`CMPC_CB_BORROW] = mux_borrow_enable_q;
    conv_ctl_b[`CMPC_CB_LEFT_ADJ] = left_adjust_q;
    conv_ctl_b[`CMPC_CB_TRIG_HI:`CMPC_CB_TRIG_LO] = trigger_select_q;
  end

  always_comb begin
    cmp_ctl = 8'h00;
    cmp_ctl[`CMPC_CTL_POWER_OFF] = cmp_power_off_q;
    cmp_ctl[`CMPC_CTL_BANDGAP] = bandgap_select_q;
    cmp_ctl[`CMPC_CTL_RESULT] = cmp_result;
    cmp_ctl[`CMPC_CTL_FLAG] = cmp_irq_flag;
    cmp_ctl[`CMPC_CTL_IRQ_EN] = cmp_irq_enable_q;
    cmp_ctl[`CMPC_CTL_ROUTE] = capture_route_enable_q;
    cmp_ctl[`CMPC_CTL_MODE_HI:`CMPC_CTL_MODE_LO] = irq_mode_q;
  end

  always_comb begin
    if (hit(ADDR_I, `CMPC_OFF_DIG_IN_DIS)) begin
      rdata_d = dig_in_dis_q;
    end else if (hit(ADDR_I, `CMPC_OFF_CONV_CTL_B)) begin
      rdata_d = conv_ctl_b;
    end else if (hit(ADDR_I, `CMPC_OFF_CMP_CTL)) begin
      rdata_d = cmp_ctl;
    end else begin
      rdata_d = 8'h00;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 8'h00;
    end else if (en) begin
      RDATA_O <= RD_I ? rdata_d : 8'h00;
    end
  end

endmodule // cmpc_top
`default_nettype wire

//--- sim/cmpc_assertions.sv
// port checker of the comparator control block
`timescale 1ns/100ps
`default_nettype none
module cmpc_assertions #(
  parameter int PIN_COUNT = 8
) (
  input wire logic CLOCK_I, // clock
  input wire logic ARST_N_I, // reset
  input wire logic CLK_EN_I, // clock enable
  input wire logic [7:0] ADDR_I, // address
  input wire logic [7:0] WDATA_I, // write data
  input wire logic WR_I, // write
  input wire logic RD_I, // read
  input wire logic [7:0] RDATA_O, // read data
  input wire logic CMP_RAW_I, // raw result
  input wire logic CONVERTER_ENABLE_I, // converter on
  input wire logic [4:0] CHANNEL_SELECT_I, // mux select
  input wire logic GLOBAL_IRQ_EN_I, // global enable
  input wire logic IRQ_ACK_I, // vector taken
  input wire logic [PIN_COUNT-1:0] PIN_BUF_OFF_O, // buffers off
  input wire logic [PIN_COUNT-1:0] PIN_READ_O, // pin reads
  input wire logic CMP_POWER_OFF_O, // power off
  input wire logic BANDGAP_SELECT_O, // bandgap
  input wire logic NEG_USE_PIN_O, // negative pin
  input wire logic [2:0] NEG_CHANNEL_O, // channel
  input wire logic CAPTURE_O, // capture
  input wire logic IRQ_O // interrupt
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  cb_unused_a: assert property ($past(RD_I && ADDR_I == 8'h03) |->
    RDATA_O[5] == 1'b0 && RDATA_O[3] == 1'b0) else $error("unused bit set");
  pin_read_a: assert property ((PIN_READ_O & PIN_BUF_OFF_O) == '0)
    else $error("disabled pin reads one");
  buf_off_a: assert property (WR_I && CLK_EN_I && ADDR_I == 8'h01 |-> ##2
    PIN_BUF_OFF_O == $past(WDATA_I, 2)) else $error("buffer disable wrong");
  ctl_out_a: assert property (WR_I && CLK_EN_I && ADDR_I == 8'h08 |-> ##2
    {CMP_POWER_OFF_O, BANDGAP_SELECT_O} == $past(WDATA_I[7:6], 2))
    else $error("power or bandgap wrong");
  neg_pin_a: assert property ($past(CONVERTER_ENABLE_I) ||
    $past(CHANNEL_SELECT_I[4:3]) != 2'h0 |-> NEG_USE_PIN_O)
    else $error("borrow while blocked");
  neg_chan_a: assert property (!NEG_USE_PIN_O |->
    NEG_CHANNEL_O == $past(CHANNEL_SELECT_I[2:0])) else $error("bad channel");
  cap_src_a: assert property (CAPTURE_O |-> $past(CMP_RAW_I, 3))
    else $error("capture without result");
  irq_gate_a: assert property (IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
    else $error("interrupt without global enable");
  ack_clear_a: assert property (IRQ_ACK_I |=> ##1 !IRQ_O)
    else $error("interrupt kept after ack");
  irq_c: cover property ($rose(IRQ_O));
  cap_c: cover property ($rose(CAPTURE_O));
  borrow_c: cover property (!NEG_USE_PIN_O);
endmodule // cmpc_assertions
bind cmpc_top cmpc_assertions #(.PIN_COUNT(PIN_COUNT)) chk_u (.*);
`default_nettype wire

//--- sim/cmpc_analog.sv
// analog front end: input levels and the comparator itself
`timescale 1ns/100ps
`default_nettype none
module cmpc_analog #(
  parameter int BANDGAP_MV = 1100
) (
  input wire logic power_off_i, // comparator unpowered
  input wire logic bandgap_i, // positive from reference
  input wire logic neg_pin_i, // negative from dedicated pin
  input wire logic [2:0] neg_chan_i, // borrowed channel
  input wire logic [11:0] pos_mv_i, // positive pin level
  input wire logic [11:0] neg_mv_i, // negative pin level
  output logic raw_o // comparator output
);
  logic [11:0] pos_mv;
  logic [11:0] neg_mv;
  assign pos_mv = bandgap_i ? 12'(BANDGAP_MV) : pos_mv_i;
  // channel n sits at n times 256 mV
  assign neg_mv = neg_pin_i ? neg_mv_i : {1'b0, neg_chan_i, 8'h00};
  assign raw_o = !power_off_i && pos_mv > neg_mv;
endmodule // cmpc_analog
`default_nettype wire

//--- sim/comparator_control_logic_test.sv
// testbench of the comparator control block
`timescale 1ns/100ps
`default_nettype none
module comparator_control_logic_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic conv = 1'b0;
  logic gie = 1'b0;
  logic ack = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] pins = 8'h00;
  logic [4:0] sel = 5'h00;
  logic [11:0] pos_mv = 12'h000;
  logic [11:0] neg_mv = 12'h1F4;
  logic [7:0] rdata, pin_rd, buf_off;
  logic [2:0] chan;
  logic raw, pwr_off, bg, use_pin, cap, irq, fr, ff;
  int num_errors = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  cmpc_top dut_u (.CLOCK_I(clk), .ARST_N_I(rst_n), .CLK_EN_I(clk_en),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CMP_RAW_I(raw), .CONVERTER_ENABLE_I(conv), .CHANNEL_SELECT_I(sel),
    .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack), .PIN_RAW_I(pins),
    .PIN_READ_O(pin_rd), .PIN_BUF_OFF_O(buf_off), .CMP_POWER_OFF_O(pwr_off),
    .BANDGAP_SELECT_O(bg), .NEG_USE_PIN_O(use_pin), .NEG_CHANNEL_O(chan),
    .CAPTURE_O(cap), .IRQ_O(irq));
  cmpc_analog ana_u (.power_off_i(pwr_off), .bandgap_i(bg),
    .neg_pin_i(use_pin), .neg_chan_i(chan), .pos_mv_i(pos_mv),
    .neg_mv_i(neg_mv), .raw_o(raw));
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, e, input string n,
                        input logic [7:0] m = 8'hFF);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata & m, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    wt(4000);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    rd_reg(8'h01, 8'h00, "did");
    rd_reg(8'h03, 8'h00, "cb");
    rd_reg(8'h08, 8'h00, "ctl");
    wr_reg(8'h05, 8'hFF);
    rd_reg(8'h05, 8'h00, "unmapped");
    pins <= 8'hFF;
    wr_reg(8'h01, 8'hA5);
    wt(2);
    chk("buf_off", buf_off, 8'hA5);
    chk("pin_read", pin_rd, 8'h5A);
    wr_reg(8'h03, 8'hFF);
    rd_reg(8'h03, 8'hD7, "cb_mask");
    wr_reg(8'h08, 8'h40);
    for (int c = 0; c < 10; c++) begin
      sel <= 5'(c);
      wt(5);
      chk("use_pin", {7'h0, use_pin}, {7'h0, c > 7});
      if (c < 8) chk("chan", {5'h0, chan}, 8'(c));
      rd_reg(8'h08, {2'h0, c > 7 || c * 256 < 1100, 5'h00}, "res", 8'h20);
    end
    sel <= 5'h00;
    conv <= 1'b1;
    wt(2);
    chk("conv_on", {7'h0, use_pin}, 8'h01);
    wr_reg(8'h08, 8'hC0);
    wt(5);
    chk("pwr", {6'h0, pwr_off, bg}, 8'h03);
    rd_reg(8'h08, 8'hC0, "pwr_res", 8'hE0);
    conv <= 1'b0;
    wr_reg(8'h08, 8'h10);
    wr_reg(8'h03, 8'h00);
    wt(4);
    for (int m = 0; m < 4; m++) begin
      gie <= m[0];
      fr = (m == 0 || m == 3);
      ff = (m == 0 || m == 2);
      wr_reg(8'h08, {6'h05, m[1:0]});
      wr_reg(8'h08, {6'h07, m[1:0]});
      pos_mv <= 12'h3E8;
      wt(6);
      chk("irq_rise", {7'h0, irq}, {7'h0, fr & m[0]});
      chk("cap_rise", {7'h0, cap}, 8'h01);
      rd_reg(8'h08, {3'h1, fr, 2'h3, m[1:0]}, "rise");
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      rd_reg(8'h08, {3'h1, 1'b0, 2'h3, m[1:0]}, "ack");
      pos_mv <= 12'h000;
      wt(6);
      chk("irq_fall", {7'h0, irq}, {7'h0, ff & m[0]});
      chk("cap_fall", {7'h0, cap}, 8'h00);
      rd_reg(8'h08, {3'h0, ff, 2'h3, m[1:0]}, "fall");
      wr_reg(8'h08, {6'h07, m[1:0]});
      rd_reg(8'h08, {3'h0, 1'b0, 2'h3, m[1:0]}, "w1c");
      wr_reg(8'h08, {6'h05, m[1:0]});
    end
    // write while the clock enable is low is not taken
    clk_en <= 1'b0;
    wr_reg(8'h01, 8'h3C);
    clk_en <= 1'b1;
    rd_reg(8'h01, 8'hA5, "frozen");
    wt(1);
    chk("rd_idle", rdata, 8'h00);
    end_of_test;
  end
endmodule // comparator_control_logic_test
`default_nettype wire
